// >>> rtl/fram_defines.svh
// Constants for the serial nonvolatile memory slave port.
// Assumes inclusion by bare name from the package and the port module.
`ifndef FRAM_DEFINES_SVH
`define FRAM_DEFINES_SVH

`define FRAM_ADDR_W      19
`define FRAM_ADDR_BYTES  2'h2
`define FRAM_SECT_W      8
`define FRAM_SN_BYTES    8
`define FRAM_DEVID_BYTES 4'h4
`define FRAM_UID_BYTES   4'h8
`define FRAM_BIT_LAST    3'h7
`define FRAM_BIT_FIRST   3'h0

`define OP_WREN          8'h06
`define OP_WRITE_DISABLE_COMMAND          8'h04
`define OP_RDSR          8'h05
`define OP_WRSR          8'h01
`define OP_READ          8'h03
`define OP_WRITE         8'h02
`define OP_SSWR          8'h42
`define OP_SSRD          8'h4b
`define OP_RDID          8'h9f
`define OP_RUID          8'h4c
`define OP_WRSN          8'hc2
`define OP_RDSN          8'hc3

`define STAT_RESET       8'h00
`define STAT_WR_MASK     8'h8c
`define STAT_LOCK_BIT    7
`define STAT_WEL_BIT     1
`define STAT_BP_HI       3
`define STAT_BP_LO       2

`define BP_NONE          2'h0
`define BP_QUARTER       2'h1
`define BP_HALF          2'h2
`define BP_ALL           2'h3

`define FIFO_DEPTH       4

`endif

// >>> rtl/fram_pkg.sv
// Types used by the serial memory port: decoder phases and write targets.
// Assumes fram_defines.svh on the include path.
`include "fram_defines.svh"

package fram_pkg;

	typedef enum logic [5:0] {
		ST_OPCODE = 6'h01,
		ST_ADDR   = 6'h02,
		ST_WDATA  = 6'h04,
		ST_RDATA  = 6'h08,
		ST_WSTAT  = 6'h10,
		ST_IGNORE = 6'h20
	} phase_t;

	typedef enum logic [1:0] {
		TGT_ARRAY  = 2'h0,
		TGT_SECTOR = 2'h1,
		TGT_SERIAL = 2'h2
	} target_t;

endpackage

// >>> rtl/commit_fifo.sv
// Small synchronous FIFO carrying committed write bytes to storage.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps

module commit_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
)(
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [PW-1:0]    wr_ptr_r;
	logic [PW-1:0]    rd_ptr_r;
	logic [PW:0]      count_r;
	wire              push = in_valid_in & in_ready_out;
	wire              pop  = out_valid_out & out_ready_in;

	assign in_ready_out  = (count_r != (PW+1)'(DEPTH));
	assign out_valid_out = (count_r != '0);
	assign out_data_out  = store[rd_ptr_r];

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == (PW)'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	always_ff @(posedge clk_in)
	begin
		if (push)
			store[wr_ptr_r] <= in_data_in;
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= ptr_inc(wr_ptr_r);
			if (pop)
				rd_ptr_r <= ptr_inc(rd_ptr_r);
			count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule // commit_fifo

// >>> rtl/fram_spi_port.sv
// Serial memory slave: pin-level SPI decoder, byte array, sector, ids.
// Assumes the link pins are asynchronous; serial clock well under CLOCK_IN/4.
`timescale 1ns/10ps
`include "fram_defines.svh"

module fram_spi_port
	import fram_pkg::*;
#(
	parameter int          ADDR_W  = `FRAM_ADDR_W,
	parameter int          SECT_W  = `FRAM_SECT_W,
	parameter int          FIFO_D  = `FIFO_DEPTH,
	parameter logic [31:0] DEV_ID  = 32'h5a3c_0104,            // Arbitrary value
	parameter logic [63:0] UNIQ_ID = 64'h0123_4567_89ab_cdef   // Arbitrary value
)(
	input  wire logic       CLOCK_IN,
	input  wire logic       RST_B_IN,
	input  wire logic       CS_B_IN,
	input  wire logic       SCK_IN,
	input  wire logic       SI_IN,
	input  wire logic       WP_B_IN,
	output logic            SO_OUT,
	output logic            SO_OE_OUT,
	output logic            SELECTED_OUT,
	output logic      [7:0] STATUS_OUT
);
	localparam int EW = 2 + ADDR_W + 8;

	// Pin synchronisers
	logic cs_s1_r;
	logic cs_s2_r;
	logic sck_s1_r;
	logic sck_s2_r;
	logic sck_d_r;
	logic si_s1_r;
	logic si_s2_r;
	logic wp_s1_r;
	logic wp_s2_r;

	phase_t            state_r;
	phase_t            state_nxt;
	logic [7:0]        cmd_r;
	logic [7:0]        cmd_nxt;
	logic [7:0]        shift_r;
	logic [7:0]        shift_nxt;
	logic [2:0]        bit_cnt_r;
	logic [2:0]        bit_cnt_nxt;
	logic [1:0]        abyte_r;
	logic [1:0]        abyte_nxt;
	logic [ADDR_W-1:0] addr_r;
	logic [ADDR_W-1:0] addr_nxt;
	logic [7:0]        tx_r;
	logic [7:0]        tx_nxt;
	logic              oe_r;
	logic              oe_nxt;
	logic [7:0]        status_r;
	logic [7:0]        status_nxt;
	logic [7:0]        rd_byte_r;
	logic              push;

	logic [7:0] mem    [0:(2**ADDR_W)-1];
	logic [7:0] sector [0:(2**SECT_W)-1];
	logic [7:0] serial [0:`FRAM_SN_BYTES-1];

	logic          fifo_in_ready;
	logic          fifo_out_valid;
	logic          fifo_out_ready;
	logic [EW-1:0] fifo_out_data;
	target_t       push_tgt;

	// Edges and decode
	wire       cs_high  = cs_s2_r;
	wire       sck_rise = ~cs_s2_r & sck_s2_r & ~sck_d_r;
	wire       sck_fall = ~cs_s2_r & ~sck_s2_r & sck_d_r;
	wire [7:0] rx_byte  = {shift_r[6:0], si_s2_r};
	wire       byte_done = sck_rise & (bit_cnt_r == `FRAM_BIT_LAST);
	wire       wel      = status_r[`STAT_WEL_BIT];
	wire       locked   = status_r[`STAT_LOCK_BIT] & ~wp_s2_r;
	wire [1:0] bp       = status_r[`STAT_BP_HI:`STAT_BP_LO];
	wire       is_read  = (cmd_r == `OP_READ) | (cmd_r == `OP_SSRD);
	wire       ary_prot = protected_at(bp, addr_r);

	// Block protection window
	function automatic logic protected_at(input logic [1:0] b, input logic [ADDR_W-1:0] a);
		case (b)
			`BP_QUARTER: protected_at = &a[ADDR_W-1:ADDR_W-2];
			`BP_HALF:    protected_at = a[ADDR_W-1];
			`BP_ALL:     protected_at = 1'b1;
			default:     protected_at = 1'b0;
		endcase
	endfunction

	// Which store a data byte of the current command goes to
	always_comb
	begin
		push_tgt = TGT_ARRAY;
		if (cmd_r == `OP_SSWR)
			push_tgt = TGT_SECTOR;
		else if (cmd_r == `OP_WRSN)
			push_tgt = TGT_SERIAL;
	end

	wire push_ok = wel & ((push_tgt != TGT_ARRAY) | ~ary_prot);
	assign push  = (state_r == ST_WDATA) & byte_done & push_ok;

	// Command decoder; holds indefinitely while the serial clock is paused
	always_comb
	begin
		state_nxt   = state_r;
		cmd_nxt     = cmd_r;
		shift_nxt   = shift_r;
		bit_cnt_nxt = bit_cnt_r;
		abyte_nxt   = abyte_r;
		addr_nxt    = addr_r;
		tx_nxt      = tx_r;
		oe_nxt      = oe_r;
		status_nxt  = status_r;
		if (cs_high)
		begin
			state_nxt   = ST_OPCODE;
			bit_cnt_nxt = `FRAM_BIT_FIRST;
			abyte_nxt   = 2'h0;
			oe_nxt      = 1'b0;
			// Permission lapses once a write-type command completes
			if ((state_r == ST_WDATA) | (state_r == ST_WSTAT))
				status_nxt[`STAT_WEL_BIT] = 1'b0;
		end
		else
		begin
			if (sck_rise)
			begin
				shift_nxt   = rx_byte;
				bit_cnt_nxt = bit_cnt_r + 3'h1;
			end
			if (byte_done)
			begin
				case (state_r)
					ST_OPCODE:
					begin
						cmd_nxt  = rx_byte;
						addr_nxt = '0;
						case (rx_byte)
							`OP_WREN:
							begin
								status_nxt[`STAT_WEL_BIT] = 1'b1;
								state_nxt = ST_IGNORE;
							end
							`OP_WRITE_DISABLE_COMMAND:
							begin
								status_nxt[`STAT_WEL_BIT] = 1'b0;
								state_nxt = ST_IGNORE;
							end
							`OP_WRSR:
								state_nxt = ST_WSTAT;
							`OP_READ, `OP_WRITE, `OP_SSWR, `OP_SSRD:
								state_nxt = ST_ADDR;
							`OP_RDSR, `OP_RDID, `OP_RUID, `OP_RDSN:
								state_nxt = ST_RDATA;
							`OP_WRSN:
								state_nxt = ST_WDATA;
							default:
								state_nxt = ST_IGNORE;
						endcase
					end
					ST_ADDR:
					begin
						// Upper five bits fall off the top of the shift
						addr_nxt  = {addr_r[ADDR_W-9:0], rx_byte};
						abyte_nxt = abyte_r + 2'h1;
						if (abyte_r == `FRAM_ADDR_BYTES)
							state_nxt = is_read ? ST_RDATA : ST_WDATA;
					end
					ST_WDATA, ST_RDATA:
						addr_nxt = addr_r + 1'b1;
					ST_WSTAT:
					begin
						if (wel & ~locked)
							status_nxt = (rx_byte & `STAT_WR_MASK) | (status_r & ~`STAT_WR_MASK);
						// Only one status byte per command
						state_nxt = ST_IGNORE;
						status_nxt[`STAT_WEL_BIT] = 1'b0;
					end
					default:
						state_nxt = state_r;
				endcase
			end
			if (sck_fall & (state_r == ST_RDATA))
			begin
				oe_nxt = 1'b1;
				if (bit_cnt_r == `FRAM_BIT_FIRST)
					tx_nxt = rd_byte_r;
				else
					tx_nxt = {tx_r[6:0], 1'b0};
			end
			if (state_r != ST_RDATA)
				oe_nxt = 1'b0;
		end
	end

	// Identity values go out most significant byte first and wrap within their length
	function automatic logic [7:0] id_byte(input logic [63:0] v, input logic [3:0] n, input logic [2:0] i);
		id_byte = v[8*(n - 4'h1 - {1'b0, i}) +: 8];
	endfunction

	// Source of the next outgoing byte
	wire [7:0] dev_byte  = id_byte({32'h0000_0000, DEV_ID}, `FRAM_DEVID_BYTES, {1'b0, addr_r[1:0]});
	wire [7:0] uniq_byte = id_byte(UNIQ_ID, `FRAM_UID_BYTES, addr_r[2:0]);
	always_ff @(posedge CLOCK_IN)
	begin
		case (cmd_r)
			`OP_RDSR: rd_byte_r <= status_r;
			`OP_RDID: rd_byte_r <= dev_byte;
			`OP_RUID: rd_byte_r <= uniq_byte;
			`OP_RDSN: rd_byte_r <= serial[addr_r[2:0]];
			`OP_SSRD: rd_byte_r <= sector[addr_r[SECT_W-1:0]];
			default:  rd_byte_r <= mem[addr_r];
		endcase
	end

	// Single storage port: reads own it during read data, buffered writes otherwise
	assign fifo_out_ready = (state_r != ST_RDATA);
	wire target_t   drain_tgt  = target_t'(fifo_out_data[EW-1 -: 2]);
	wire [ADDR_W-1:0] drain_addr = fifo_out_data[ADDR_W+7:8];
	wire [7:0]      drain_data = fifo_out_data[7:0];
	wire            drain      = fifo_out_valid & fifo_out_ready;

	always_ff @(posedge CLOCK_IN)
	begin
		if (drain)
		begin
			case (drain_tgt)
				TGT_SECTOR: sector[drain_addr[SECT_W-1:0]] <= drain_data;
				TGT_SERIAL: serial[drain_addr[2:0]] <= drain_data;
				default:    mem[drain_addr] <= drain_data;
			endcase
		end
	end

	// Buffer absorbs bytes arriving while the port is busy; a full buffer drops the byte
	commit_fifo #(
		.WIDTH (EW),
		.DEPTH (FIFO_D)
	) u_commit (
		.clk_in        (CLOCK_IN),
		.rst_b_in      (RST_B_IN),
		.in_valid_in   (push),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    ({push_tgt, addr_r, rx_byte}),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (fifo_out_ready),
		.out_data_out  (fifo_out_data)
	);

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			cs_s1_r  <= 1'b1;
			cs_s2_r  <= 1'b1;
			sck_s1_r <= 1'b0;
			sck_s2_r <= 1'b0;
			sck_d_r  <= 1'b0;
			si_s1_r  <= 1'b0;
			si_s2_r  <= 1'b0;
			wp_s1_r  <= 1'b1;
			wp_s2_r  <= 1'b1;
		end
		else
		begin
			cs_s1_r  <= CS_B_IN;
			cs_s2_r  <= cs_s1_r;
			sck_s1_r <= SCK_IN;
			sck_s2_r <= sck_s1_r;
			sck_d_r  <= sck_s2_r;
			si_s1_r  <= SI_IN;
			si_s2_r  <= si_s1_r;
			wp_s1_r  <= WP_B_IN;
			wp_s2_r  <= wp_s1_r;
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			state_r   <= ST_OPCODE;
			cmd_r     <= 8'h00;
			shift_r   <= 8'h00;
			bit_cnt_r <= `FRAM_BIT_FIRST;
			abyte_r   <= 2'h0;
			addr_r    <= '0;
			tx_r      <= 8'h00;
			oe_r      <= 1'b0;
			status_r  <= `STAT_RESET;
		end
		else
		begin
			state_r   <= state_nxt;
			cmd_r     <= cmd_nxt;
			shift_r   <= shift_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			abyte_r   <= abyte_nxt;
			addr_r    <= addr_nxt;
			tx_r      <= tx_nxt;
			oe_r      <= oe_nxt;
			status_r  <= status_nxt;
		end
	end

	assign SO_OUT       = oe_r & tx_r[7];
	assign SO_OE_OUT    = oe_r;
	assign SELECTED_OUT = ~cs_s2_r;
	assign STATUS_OUT   = status_r;
endmodule // fram_spi_port

// >>> verif/spi_master_model.sv
// Behavioural SPI master for the serial memory port, modes 0 and 3.
// Assumes a slow link: half period 100 ns, launched 7 ns after a clock edge.
`timescale 1ns/10ps

module spi_master_model (
	input  wire logic clk_in,
	input  wire logic so_in,
	output logic      cs_b_out,
	output logic      sck_out,
	output logic      si_out
);
	localparam time HALF = 100ns;
	logic [7:0] txq [$];
	logic [7:0] rxq [$];
	logic       mode3;
	logic       pause;

	initial
	begin
		cs_b_out = 1'b1;
		sck_out = 1'b0;
		si_out = 1'b0;
		mode3 = 1'b0;
		pause = 1'b0;
	end

	task automatic frame();
		logic [7:0] r;
		rxq = {};
		@(posedge clk_in);
		#7;
		sck_out = mode3;
		#HALF;
		cs_b_out = 1'b0;
		#HALF;
		foreach (txq[i])
		begin
			for (int k = 7; k >= 0; k--)
			begin
				sck_out = 1'b0;
				si_out = txq[i][k];
				#HALF;
				sck_out = 1'b1;
				if (pause && k == 3)
					#(6*HALF);
				#HALF;
				// Sampled late: the port's sync delay eats the low phase
				r[k] = so_in;
			end
			rxq.push_back(r);
		end
		sck_out = mode3;
		#HALF;
		cs_b_out = 1'b1;
		si_out = ~si_out;
		#HALF;
	endtask
endmodule // spi_master_model

// >>> verif/fram_spi_port_props.sv
// Pin-level checker for the serial memory slave port.
// Assumes it sees only the top ports; link pins are slow against CLOCK_IN.
`timescale 1ns/10ps

module spi_port_checker (
	input wire logic       CLOCK_IN,
	input wire logic       RST_B_IN,
	input wire logic       CS_B_IN,
	input wire logic       SCK_IN,
	input wire logic       SI_IN,
	input wire logic       WP_B_IN,
	input wire logic       SO_OUT,
	input wire logic       SO_OE_OUT,
	input wire logic       SELECTED_OUT,
	input wire logic [7:0] STATUS_OUT
);
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (!RST_B_IN);

	property p_so_idle;
		!SO_OE_OUT |-> SO_OUT == 1'b0;
	endproperty
	a_so_idle: assert property (p_so_idle) else $error("output not low while released");
	property p_standby;
		CS_B_IN [*5] |-> !SO_OE_OUT && !SELECTED_OUT;
	endproperty
	a_standby: assert property (p_standby) else $error("active while deselected");
	property p_select;
		!CS_B_IN [*4] |-> SELECTED_OUT;
	endproperty
	a_select: assert property (p_select) else $error("select not seen");
	property p_sel_rise;
		$rose(SELECTED_OUT) |-> !$past(CS_B_IN, 2);
	endproperty
	a_sel_rise: assert property (p_sel_rise) else $error("select without chip select");
	property p_oe_rise;
		$rose(SO_OE_OUT) |-> SELECTED_OUT && (!$past(SCK_IN, 2) || !$past(SCK_IN, 3));
	endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("drive began off a falling edge");
	property p_so_fall;
		SO_OE_OUT && $past(SO_OE_OUT) && $changed(SO_OUT) |-> !$past(SCK_IN, 2) || !$past(SCK_IN, 3);
	endproperty
	a_so_fall: assert property (p_so_fall) else $error("output moved off a falling edge");
	property p_oe_drop;
		!SELECTED_OUT [*2] |-> !SO_OE_OUT;
	endproperty
	a_oe_drop: assert property (p_oe_drop) else $error("drive kept after deselect");
	property p_lock;
		(STATUS_OUT[7] && !WP_B_IN) [*6] |-> $stable(STATUS_OUT[7:2]);
	endproperty
	a_lock: assert property (p_lock) else $error("locked status changed");
	property p_status_sel;
		$changed(STATUS_OUT[7:2]) |-> SELECTED_OUT;
	endproperty
	a_status_sel: assert property (p_status_sel) else $error("status moved while idle");
endmodule // spi_port_checker

bind fram_spi_port spi_port_checker chk_i (
	.CLOCK_IN     (CLOCK_IN),
	.RST_B_IN     (RST_B_IN),
	.CS_B_IN      (CS_B_IN),
	.SCK_IN       (SCK_IN),
	.SI_IN        (SI_IN),
	.WP_B_IN      (WP_B_IN),
	.SO_OUT       (SO_OUT),
	.SO_OE_OUT    (SO_OE_OUT),
	.SELECTED_OUT (SELECTED_OUT),
	.STATUS_OUT   (STATUS_OUT)
);

// >>> verif/tb_top.sv
// Self-checking bench for the serial memory slave port.
// Assumes the master model drives the link and the checker is bound.
`timescale 1ns/10ps
`include "fram_defines.svh"

module tb_top;
	logic        clk;
	logic        rst_b;
	logic        wp_b;
	logic        cs_b;
	logic        sck;
	logic        si;
	logic        so;
	logic        so_oe;
	logic        sel;
	logic [7:0]  status;
	wire         so_line;
	int          oe_cycles = 0;
	// Arbitrary identity values for the bench
	localparam logic [31:0] DEV_ID_T  = 32'h1e2d_3c4b;
	localparam logic [63:0] UNIQ_ID_T = 64'h0f1e_2d3c_4b5a_6978;
	logic [7:0]  mem [3];
	logic [18:0] pa [3];
	int          n_fail = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	// Released output floats high on the board
	assign so_line = so_oe ? so : 1'b1;

	fram_spi_port #(
		.DEV_ID  (DEV_ID_T),
		.UNIQ_ID (UNIQ_ID_T)
	) uut (
		.CLOCK_IN     (clk),
		.RST_B_IN     (rst_b),
		.CS_B_IN      (cs_b),
		.SCK_IN       (sck),
		.SI_IN        (si),
		.WP_B_IN      (wp_b),
		.SO_OUT       (so),
		.SO_OE_OUT    (so_oe),
		.SELECTED_OUT (sel),
		.STATUS_OUT   (status)
	);
	spi_master_model m (
		.clk_in   (clk),
		.so_in    (so_line),
		.cs_b_out (cs_b),
		.sck_out  (sck),
		.si_out   (si)
	);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (so_oe)
			oe_cycles <= oe_cycles + 1;
		if (cyc == 60000)
		begin
			n_fail++;
			final_report();
		end
	end

	function automatic logic prot(input int bp, input logic [18:0] a);
		return bp == 3 || (bp == 2 && a >= 19'h40000) || (bp == 1 && a >= 19'h60000);
	endfunction

	task automatic go(input logic [7:0] q [$]);
		m.txq = q;
		m.mode3 = 1'($urandom_range(1, 0));
		m.frame();
	endtask

	task automatic wrsr(input logic [7:0] v);
		go('{`OP_WREN});
		go('{`OP_WRSR, v});
	endtask

	task automatic rd(input logic [23:0] a, output logic [7:0] d0, output logic [7:0] d1);
		go('{`OP_READ, a[23:16], a[15:8], a[7:0], 8'h00, 8'h00});
		d0 = m.rxq[4];
		d1 = m.rxq[5];
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		logic [7:0] d0, d1, x0, x1;
		logic [7:0] q [$];
		int         oe0;
		rst_b = 1'b0;
		wp_b = 1'b1;
		void'($urandom(32'h017b108e));
		repeat (10) @(posedge clk);
		#7;
		rst_b = 1'b1;
		chk("status", `STAT_RESET, status);
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		// Top address wraps; junk upper bits; clock paused mid-byte
		m.pause = 1'b1;
		go('{`OP_WREN});
		go('{`OP_WRITE, 8'hff, 8'hff, 8'hff, d0, d1});
		m.pause = 1'b0;
		chk("status", 8'h00, status);
		rd(24'h07ffff, x0, x1);
		chk("rd_top", d0, x0);
		chk("rd_wrap", d1, x1);
		go('{`OP_WREN});
		chk("status", 8'h02, status);
		go('{`OP_WRITE_DISABLE_COMMAND});
		chk("status", 8'h00, status);
		go('{`OP_WRITE, 8'h07, 8'hff, 8'hff, ~d0});
		rd(24'h07ffff, x0, x1);
		chk("rd_write_disable_command", d0, x0);
		oe0 = oe_cycles;
		go('{8'h77, `OP_READ, 8'h07, 8'hff, 8'hff, 8'h00});
		chk("oe_unknown", 8'h00, 8'(oe_cycles - oe0));
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		go('{`OP_WREN});
		go('{`OP_SSWR, 8'h00, 8'h00, d1, d0});
		go('{`OP_SSRD, 8'h00, 8'h00, d1, 8'h00});
		chk("sector", d0, m.rxq[4]);
		// Probes just across the quarter and half boundaries
		pa = '{19'h60000, 19'h5ffff, 19'h3ffff};
		for (int bp = 0; bp < 4; bp++)
		begin
			wrsr(8'(bp << 2) | 8'h71);
			chk("status", (8'(bp << 2) | 8'h71) & `STAT_WR_MASK, status);
			for (int p = 0; p < 3; p++)
			begin
				d0 = 8'($urandom);
				go('{`OP_WREN});
				go('{`OP_WRITE, {5'h00, pa[p][18:16]}, pa[p][15:8], pa[p][7:0], d0});
				if (!prot(bp, pa[p]))
					mem[p] = d0;
				rd({5'h00, pa[p]}, x0, x1);
				chk("rd_bp", mem[p], x0);
			end
		end
		wrsr(8'h80);
		wp_b = 1'b0;
		wrsr(8'h0c);
		chk("status_lock", 8'h80, status & 8'hfc);
		wp_b = 1'b1;
		wrsr(8'h0c);
		chk("status_free", 8'h0c, status);
		// Serial number round trip, then the read-only identities
		q = {`OP_WRSN};
		for (int i = 0; i < 8; i++)
			q.push_back(8'($urandom));
		go('{`OP_WREN});
		go(q);
		go('{`OP_RDSN, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
		for (int i = 1; i < 9; i++)
			chk("serial", q[i], m.rxq[i]);
		go('{`OP_RUID, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
		for (int i = 1; i < 9; i++)
			chk("uniq_id", UNIQ_ID_T[8*(8-i) +: 8], m.rxq[i]);
		go('{`OP_RDID, 8'h00, 8'h00, 8'h00, 8'h00});
		for (int i = 1; i < 5; i++)
			chk("dev_id", DEV_ID_T[8*(4-i) +: 8], m.rxq[i]);
		go('{`OP_RDSR, 8'h00});
		chk("rdsr", 8'h0c, m.rxq[1]);
		final_report();
	end
endmodule // tb_top
